// File: common/mcu_interrupt_control_pkg.sv
package mcu_interrupt_control_pkg;

    // Register indices and their APB byte addresses (index times four)
    localparam logic [7:0] IDX_INT_CTRL_FIRST  = 8'h0B;
    localparam logic [7:0] IDX_INT_CTRL_SECOND = 8'h1E;
    localparam logic [7:0] IDX_REMOTE_CTRL     = 8'h21;
    localparam logic [7:0] IDX_MF_FLAGS        = 8'h29;
    localparam logic [7:0] IDX_CORE_STATE      = 8'h30;
    localparam logic [9:0] ADDR_INT_CTRL_FIRST  = {IDX_INT_CTRL_FIRST, 2'b00};
    localparam logic [9:0] ADDR_INT_CTRL_SECOND = {IDX_INT_CTRL_SECOND, 2'b00};
    localparam logic [9:0] ADDR_REMOTE_CTRL     = {IDX_REMOTE_CTRL, 2'b00};
    localparam logic [9:0] ADDR_MF_FLAGS        = {IDX_MF_FLAGS, 2'b00};
    localparam logic [9:0] ADDR_CORE_STATE      = {IDX_CORE_STATE, 2'b00};

    // Field positions, first control register
    localparam int BIT_GLOBAL_EN   = 0;
    localparam int BIT_EXT0_EN     = 1;
    localparam int BIT_EXT1_EN     = 2;
    localparam int BIT_CNT0_EN     = 3;
    localparam int BIT_EXT0_PEND   = 4;
    localparam int BIT_EXT1_PEND   = 5;
    localparam int BIT_CNT0_PEND   = 6;
    // Field positions, second control register
    localparam int BIT_CNT1_EN     = 0;
    localparam int BIT_SERIAL_EN   = 1;
    localparam int BIT_MF_EN       = 2;
    localparam int BIT_CNT1_PEND   = 4;
    localparam int BIT_SERIAL_PEND = 5;
    localparam int BIT_MF_PEND     = 6;
    // Field positions, remote timer control register
    localparam int BIT_RISE_EN     = 1;
    localparam int BIT_FALL_EN     = 2;
    localparam int BIT_OVF_EN      = 3;
    localparam int BIT_RUN         = 4;
    localparam int BIT_CLK_SRC     = 5;
    localparam int BIT_DIV_LO      = 6;
    localparam int BIT_DIV_HI      = 7;
    // Field positions, multi-function source flags
    localparam int BIT_MF_OVF      = 0;
    localparam int BIT_MF_RTC      = 1;
    localparam int BIT_MF_RISE     = 2;
    localparam int BIT_MF_FALL     = 3;
    localparam int BIT_MF_RTC_EN   = 4;

    // Writable bit masks; other bits read as zero
    localparam logic [7:0] MASK_INT_CTRL  = 8'h7F;
    localparam logic [7:0] MASK_SECOND    = 8'h77;
    localparam logic [7:0] MASK_REMOTE    = 8'hFE;
    localparam logic [7:0] MASK_MF_FLAGS  = 8'h1F;

    // Reset values
    localparam logic [7:0] RST_INT_CTRL_FIRST  = 8'h00;
    localparam logic [7:0] RST_INT_CTRL_SECOND = 8'h00;
    localparam logic [7:0] RST_REMOTE_CTRL     = 8'h00;
    localparam logic [7:0] RST_MF_FLAGS        = 8'h00;

    // Vector locations, highest priority first
    localparam logic [7:0] VEC_EXT0   = 8'h04;
    localparam logic [7:0] VEC_EXT1   = 8'h08;
    localparam logic [7:0] VEC_CNT0   = 8'h0C;
    localparam logic [7:0] VEC_CNT1   = 8'h10;
    localparam logic [7:0] VEC_SERIAL = 8'h14;
    localparam logic [7:0] VEC_MF     = 8'h18;

    // Remote timer prescale: base exponent, extra for source divided by four
    localparam logic [3:0] DIV_BASE_EXP = 4'h5;
    localparam logic [3:0] SRC_DIV4_EXP = 4'h2;

    // Peripheral events, one-cycle pulses on the system clock
    typedef struct packed {
        logic ext0;
        logic ext1;
        logic counter0;
        logic counter1;
        logic serial_done;
        logic rtc_tick;
    } irq_events_t;

    // Acknowledge to the sequencer: push the PC, then branch to vector
    typedef struct packed {
        logic       push_pc;
        logic [7:0] vector;
    } irq_ack_t;

endpackage : mcu_interrupt_control_pkg

// File: hw/mcu_interrupt_control.sv
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/10ps
module mcu_interrupt_control
(
    // Clock and reset
    input  wire logic                               i_clock,
    input  wire logic                               i_nrst,
    // APB slave
    input  wire logic                               i_psel,
    input  wire logic                               i_penable,
    input  wire logic                               i_pwrite,
    input  wire logic [9:0]                         i_paddr,
    input  wire logic [31:0]                        i_pwdata,
    input  wire logic [3:0]                         i_pstrb,
    output logic      [31:0]                        o_prdata,
    output logic                                    o_pready,
    output logic                                    o_pslverr,
    // Peripheral events and remote control pin
    input  wire mcu_interrupt_control_pkg::irq_events_t i_events,
    input  wire logic                               i_remote_pin,
    // CPU sequencer
    input  wire logic                               i_instr_boundary,
    input  wire logic                               i_stack_full,
    input  wire logic                               i_return_from_interrupt,
    output mcu_interrupt_control_pkg::irq_ack_t     o_ack,
    output logic                                    o_wake
);

    // Interrupt control registers
    logic [7:0] ctrl_first_r;                 // Global/source enables, pending flags
    logic [7:0] ctrl_second_r;                // Second enables and pending flags
    logic [7:0] remote_ctrl_r;                // Remote timer control
    logic [7:0] mf_flags_r;                   // Multi-function sub-source flags
    logic [7:0] last_vector_r;                // Last vector taken
    // Remote timer
    logic [10:0] presc_r;                     // Source prescaler
    logic [7:0]  remote_cnt_r;                // Remote timer counter
    logic        remote_ovf;                  // Counter wraps this cycle
    logic        presc_tick;                  // Prescaler terminal count
    logic [3:0]  div_exp;                     // Total prescale exponent
    logic [10:0] presc_mask;                  // Low bits that must be all ones
    // Remote pin synchroniser and edge detect
    logic        pin_meta_r;                  // First stage, read only by second
    logic        pin_sync_r;                  // Second stage
    logic        pin_prev_r;                  // Delayed copy for edges
    logic        remote_rise;                 // Rising edge seen
    logic        remote_fall;                 // Falling edge seen
    // Multi-function request generation
    logic        mf_event;                    // An enabled sub-source fired
    // Bus decode
    logic        bus_setup;                   // Setup phase of a transfer
    logic        bus_write;                   // Write completes this edge
    logic        wr_first;                    // Write hits first register
    logic        wr_second;                   // Write hits second register
    logic        wr_remote;                   // Write hits remote control
    logic        wr_mf;                       // Write hits sub-source flags
    logic        addr_hit;                    // Address is mapped
    logic [7:0]  wbyte;                       // Low write byte
    logic [7:0]  rd_mux;                      // Read data selection
    // Arbitration
    logic [5:0]  req_vec;                     // Enabled pending, priority order
    logic        take;                        // Acknowledge this edge
    logic [7:0]  take_vector;                 // Vector of the winner
    logic [5:0]  take_onehot;                 // Winner as one-hot

    // Bus phase and decode
    assign bus_setup = i_psel && !i_penable;
    assign bus_write = i_psel && i_penable && o_pready && i_pwrite && i_pstrb[0];
    assign wbyte     = i_pwdata[7:0];
    assign wr_first  = bus_write && (i_paddr == mcu_interrupt_control_pkg::ADDR_INT_CTRL_FIRST);
    assign wr_second = bus_write && (i_paddr == mcu_interrupt_control_pkg::ADDR_INT_CTRL_SECOND);
    assign wr_remote = bus_write && (i_paddr == mcu_interrupt_control_pkg::ADDR_REMOTE_CTRL);
    assign wr_mf     = bus_write && (i_paddr == mcu_interrupt_control_pkg::ADDR_MF_FLAGS);

    // Read mux and address check
    always_comb
    begin
        addr_hit = 1'b1;
        unique case (i_paddr)
            mcu_interrupt_control_pkg::ADDR_INT_CTRL_FIRST:
                rd_mux = ctrl_first_r;
            mcu_interrupt_control_pkg::ADDR_INT_CTRL_SECOND:
                rd_mux = ctrl_second_r;
            mcu_interrupt_control_pkg::ADDR_REMOTE_CTRL:
                rd_mux = remote_ctrl_r;
            mcu_interrupt_control_pkg::ADDR_MF_FLAGS:
                rd_mux = mf_flags_r;
            mcu_interrupt_control_pkg::ADDR_CORE_STATE:
                rd_mux = last_vector_r;
            default:
            begin
                // Unmapped address answers zero with error
                rd_mux   = 8'h00;
                addr_hit = 1'b0;
            end
        endcase
    end

    // APB answer: ready one cycle after setup, data and error with it
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            o_pready  <= 1'b0;
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end
        else if (bus_setup)
        begin
            o_pready  <= 1'b1;
            o_prdata  <= {24'h00_0000, rd_mux};
            o_pslverr <= !addr_hit;
        end
        else
        begin
            o_pready  <= 1'b0;
            o_pslverr <= 1'b0;
        end
    end

    // Remote pin: two flip-flops, then edge detect on the second
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            pin_meta_r <= 1'b0;
            pin_sync_r <= 1'b0;
            pin_prev_r <= 1'b0;
        end
        else
        begin
            pin_meta_r <= i_remote_pin;
            pin_sync_r <= pin_meta_r;
            pin_prev_r <= pin_sync_r;
        end
    end

    assign remote_rise = pin_sync_r && !pin_prev_r;
    assign remote_fall = !pin_sync_r && pin_prev_r;

    // Prescale exponent from source and divider code
    always_comb
    begin
        div_exp = mcu_interrupt_control_pkg::DIV_BASE_EXP
                + {2'b00, remote_ctrl_r[mcu_interrupt_control_pkg::BIT_DIV_HI],
                          remote_ctrl_r[mcu_interrupt_control_pkg::BIT_DIV_LO]};
        if (!remote_ctrl_r[mcu_interrupt_control_pkg::BIT_CLK_SRC])
        begin
            div_exp = div_exp + mcu_interrupt_control_pkg::SRC_DIV4_EXP;
        end
        presc_mask = 11'((12'h001 << div_exp) - 12'h001);
    end

    assign presc_tick = ((presc_r & presc_mask) == presc_mask);
    assign remote_ovf = presc_tick && (remote_cnt_r == 8'hFF)
                     && remote_ctrl_r[mcu_interrupt_control_pkg::BIT_RUN];

    // Remote timer counting
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            presc_r      <= 11'h000;
            remote_cnt_r <= 8'h00;
        end
        else if (!remote_ctrl_r[mcu_interrupt_control_pkg::BIT_RUN])
        begin
            presc_r      <= 11'h000;
            remote_cnt_r <= 8'h00;
        end
        else
        begin
            presc_r <= presc_r + 11'h001;
            if (presc_tick)
            begin
                remote_cnt_r <= remote_cnt_r + 8'h01;
            end
        end
    end

    // Remote timer control register
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            remote_ctrl_r <= mcu_interrupt_control_pkg::RST_REMOTE_CTRL;
        end
        else if (wr_remote)
        begin
            remote_ctrl_r <= wbyte & mcu_interrupt_control_pkg::MASK_REMOTE;
        end
    end

    // Multi-function sub-source flags
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            mf_flags_r <= mcu_interrupt_control_pkg::RST_MF_FLAGS;
        end
        else
        begin
            mf_flags_r <= (wr_mf ? (wbyte & mcu_interrupt_control_pkg::MASK_MF_FLAGS)
                                 : mf_flags_r)
                        | {4'h0, remote_fall, remote_rise, i_events.rtc_tick, remote_ovf};
        end
    end

    // Enabled sub-source raises the multi-function request
    always_comb
    begin
        // remote and rtc feed the multi-function source
        mf_event = (remote_ovf && remote_ctrl_r[mcu_interrupt_control_pkg::BIT_OVF_EN])
                || (remote_rise && remote_ctrl_r[mcu_interrupt_control_pkg::BIT_RISE_EN])
                || (remote_fall && remote_ctrl_r[mcu_interrupt_control_pkg::BIT_FALL_EN])
                || (i_events.rtc_tick && mf_flags_r[mcu_interrupt_control_pkg::BIT_MF_RTC_EN]);
    end

    // Enabled pending requests in priority order, bit 0 highest
    always_comb
    begin
        req_vec[2:0] = ctrl_first_r[mcu_interrupt_control_pkg::BIT_CNT0_PEND:
                                    mcu_interrupt_control_pkg::BIT_EXT0_PEND]
                     & ctrl_first_r[mcu_interrupt_control_pkg::BIT_CNT0_EN:
                                    mcu_interrupt_control_pkg::BIT_EXT0_EN];
        req_vec[5:3] = ctrl_second_r[mcu_interrupt_control_pkg::BIT_MF_PEND:
                                     mcu_interrupt_control_pkg::BIT_CNT1_PEND]
                     & ctrl_second_r[mcu_interrupt_control_pkg::BIT_MF_EN:
                                     mcu_interrupt_control_pkg::BIT_CNT1_EN];
    end

    // Fixed priority pick and acknowledge condition
    always_comb
    begin
        take_onehot = 6'h00;
        take_vector = 8'h00;
        // scan lowest priority first, so the highest one is kept
        for (int i = 5; i >= 0; i--)
        begin
            if (req_vec[i])
            begin
                take_onehot = 6'h01 << i;
                take_vector = mcu_interrupt_control_pkg::VEC_EXT0 + 8'(4 * i);
            end
        end
        // global gate, stack full blocks, flags only
        take = (|req_vec) && i_instr_boundary && !i_stack_full
            && ctrl_first_r[mcu_interrupt_control_pkg::BIT_GLOBAL_EN]
            && !o_ack.push_pc;
    end

    // First control register: enables, global gate and pending flags
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            ctrl_first_r <= mcu_interrupt_control_pkg::RST_INT_CTRL_FIRST;
        end
        else
        begin
            ctrl_first_r <= (wr_first ? (wbyte & mcu_interrupt_control_pkg::MASK_INT_CTRL)
                                      : ctrl_first_r);
            if (take)
            begin
                ctrl_first_r[mcu_interrupt_control_pkg::BIT_GLOBAL_EN] <= 1'b0;
            end
            else if (i_return_from_interrupt)
            begin
                ctrl_first_r[mcu_interrupt_control_pkg::BIT_GLOBAL_EN] <= 1'b1;
            end
            if (take && take_onehot[0])
            begin
                ctrl_first_r[mcu_interrupt_control_pkg::BIT_EXT0_PEND] <= 1'b0;
            end
            if (take && take_onehot[1])
            begin
                ctrl_first_r[mcu_interrupt_control_pkg::BIT_EXT1_PEND] <= 1'b0;
            end
            if (take && take_onehot[2])
            begin
                ctrl_first_r[mcu_interrupt_control_pkg::BIT_CNT0_PEND] <= 1'b0;
            end
            // a new event always sets its flag
            if (i_events.ext0)
            begin
                ctrl_first_r[mcu_interrupt_control_pkg::BIT_EXT0_PEND] <= 1'b1;
            end
            if (i_events.ext1)
            begin
                ctrl_first_r[mcu_interrupt_control_pkg::BIT_EXT1_PEND] <= 1'b1;
            end
            if (i_events.counter0)
            begin
                ctrl_first_r[mcu_interrupt_control_pkg::BIT_CNT0_PEND] <= 1'b1;
            end
        end
    end

    // Second control register: enables and pending flags
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            ctrl_second_r <= mcu_interrupt_control_pkg::RST_INT_CTRL_SECOND;
        end
        else
        begin
            // software view, bits 3 and 7 zero
            ctrl_second_r <= (wr_second ? (wbyte & mcu_interrupt_control_pkg::MASK_SECOND)
                                        : ctrl_second_r);
            if (take && take_onehot[3])
            begin
                ctrl_second_r[mcu_interrupt_control_pkg::BIT_CNT1_PEND] <= 1'b0;
            end
            if (take && take_onehot[4])
            begin
                ctrl_second_r[mcu_interrupt_control_pkg::BIT_SERIAL_PEND] <= 1'b0;
            end
            if (take && take_onehot[5])
            begin
                ctrl_second_r[mcu_interrupt_control_pkg::BIT_MF_PEND] <= 1'b0;
            end
            // a new event always sets its flag
            if (i_events.counter1)
            begin
                ctrl_second_r[mcu_interrupt_control_pkg::BIT_CNT1_PEND] <= 1'b1;
            end
            if (i_events.serial_done)
            begin
                ctrl_second_r[mcu_interrupt_control_pkg::BIT_SERIAL_PEND] <= 1'b1;
            end
            if (mf_event)
            begin
                ctrl_second_r[mcu_interrupt_control_pkg::BIT_MF_PEND] <= 1'b1;
            end
        end
    end

    // Acknowledge pulse to the sequencer
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            o_ack         <= '0;
            last_vector_r <= 8'h00;
        end
        // push PC only, status not saved
        else if (take)
        begin
            o_ack.push_pc <= 1'b1;
            o_ack.vector  <= take_vector;
            last_vector_r <= take_vector;
        end
        else
        begin
            o_ack.push_pc <= 1'b0;
        end
    end

    // Wake request from any pending flag
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            o_wake <= 1'b0;
        end
        else
        begin
            o_wake <= (|ctrl_first_r[mcu_interrupt_control_pkg::BIT_CNT0_PEND:
                                      mcu_interrupt_control_pkg::BIT_EXT0_PEND])
                   || (|ctrl_second_r[mcu_interrupt_control_pkg::BIT_MF_PEND:
                                      mcu_interrupt_control_pkg::BIT_CNT1_PEND]);
        end
    end

endmodule : mcu_interrupt_control

// File: sim/mcu_interrupt_control_monitor.sv
`timescale 1ns/10ps
// Bus and acknowledge timing watched at the controller ports
module mcu_interrupt_control_monitor
(
    // Clock and reset
    input wire logic                                i_clock,
    input wire logic                                i_nrst,
    // Bus, sequencer and acknowledge
    input wire logic                                i_psel,
    input wire logic                                i_penable,
    input wire logic                                i_instr_boundary,
    input wire logic                                i_stack_full,
    input wire logic                                i_return_from_interrupt,
    input wire logic                                o_pready,
    input wire logic                                o_pslverr,
    input wire mcu_interrupt_control_pkg::irq_ack_t o_ack,
    input wire logic                                o_wake
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);
    property p_rdy; i_psel && !i_penable |=> o_pready; endproperty
    property p_rdy1; o_pready |=> !o_pready; endproperty
    property p_err; o_pslverr |-> o_pready; endproperty
    property p_full; i_stack_full |=> !o_ack.push_pc; endproperty
    property p_bnd; !i_instr_boundary |=> !o_ack.push_pc; endproperty
    property p_push1; o_ack.push_pc |=> !o_ack.push_pc; endproperty
    property p_vec; o_ack.push_pc |-> o_ack.vector[1:0] == 2'h0
        && o_ack.vector >= 8'h04 && o_ack.vector <= 8'h18; endproperty
    property p_wake; o_ack.push_pc |-> o_wake; endproperty
    // No new entry without return or register write
    property p_blk; (o_ack.push_pc && !i_return_from_interrupt && !i_psel)
        ##1 (!i_return_from_interrupt && !i_psel) |=> !o_ack.push_pc; endproperty
    a_rdy: assert property (p_rdy) else $error("no ready after setup");
    a_rdy1: assert property (p_rdy1) else $error("ready too long");
    a_err: assert property (p_err) else $error("error without ready");
    a_full: assert property (p_full) else $error("ack with full stack");
    a_bnd: assert property (p_bnd) else $error("ack off boundary");
    a_push1: assert property (p_push1) else $error("push too long");
    a_vec: assert property (p_vec) else $error("bad vector");
    a_wake: assert property (p_wake) else $error("no wake");
    a_blk: assert property (p_blk) else $error("nested ack");
    c_ack: cover property (o_ack.push_pc);
    c_err: cover property (o_pslverr);
    c_ret: cover property (i_return_from_interrupt ##2 o_ack.push_pc);
endmodule : mcu_interrupt_control_monitor

// File: sim/cpu_sequencer_model.sv
`timescale 1ns/10ps
// Sequencer: boundaries, PC stack depth, automatic returns
module cpu_sequencer_model #(parameter int DEPTH = 6)
(
    // Clock, reset and bench control
    input  wire logic                                i_clock,
    input  wire logic                                i_nrst,
    input  wire logic                                i_hold_full,
    input  wire logic                                i_auto_ret,
    input  wire mcu_interrupt_control_pkg::irq_ack_t i_ack,
    // Toward the controller
    output logic                                     o_boundary,
    output logic                                     o_stack_full,
    output logic                                     o_ret_int
);
    logic [2:0] depth_r;  // Saved PC count
    assign o_stack_full = i_hold_full || (depth_r == 3'(DEPTH));
    // PC only pushed, status never saved
    always_ff @(posedge i_clock)
    begin
        if (!i_nrst)
        begin
            depth_r <= 3'h0;
            o_boundary <= 1'b0;
            o_ret_int <= 1'b0;
        end
        else
        begin
            depth_r <= depth_r + 3'(i_ack.push_pc) - 3'(o_ret_int);
            o_boundary <= ~o_boundary;
            o_ret_int <= i_auto_ret && depth_r != 3'h0 && !o_ret_int && !i_ack.push_pc;
        end
    end
endmodule : cpu_sequencer_model

// File: sim/mcu_interrupt_control_tb.sv
`timescale 1ns/10ps
// Register, blocking and priority checks of the interrupt controller
module mcu_interrupt_control_tb;
    logic clk = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [9:0] paddr = 10'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    mcu_interrupt_control_pkg::irq_events_t events = '0;
    mcu_interrupt_control_pkg::irq_ack_t ack;
    logic pin = 0, bnd, full, ret_int, wake, hold = 1, auto_ret = 0, e;
    logic [7:0] q, d, vq[$];
    int seed = 22, n_errors = 0, compares = 0;
    logic [9:0] adr [4] = '{10'h02C, 10'h078, 10'h084, 10'h0A4};
    logic [7:0] msk [4] = '{8'h7F, 8'h77, 8'hFE, 8'h1F};
    always #4 clk = ~clk;
    mcu_interrupt_control uut (.i_clock(clk), .i_nrst(nrst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .i_pstrb(4'hF), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .i_events(events), .i_remote_pin(pin), .i_instr_boundary(bnd),
        .i_stack_full(full), .i_return_from_interrupt(ret_int), .o_ack(ack), .o_wake(wake));
    cpu_sequencer_model seq (.i_clock(clk), .i_nrst(nrst), .i_hold_full(hold),
        .i_auto_ret(auto_ret), .i_ack(ack), .o_boundary(bnd), .o_stack_full(full),
        .o_ret_int(ret_int));
    // Taken vectors, sampled while the push stands
    always @(posedge clk) if (ack.push_pc === 1'b1) vq.push_back(ack.vector);
    // One APB transfer, waits for ready
    task automatic apb(input logic w, input logic [9:0] a, input logic [7:0] v);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, 24'h0, v};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata[7:0];
        e = pslverr;
        {psel, penable} <= 2'b00;
    endtask : apb
    task automatic chk_reg(input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %0t register exp %h got %h", $time, exp, got);
        end
    endtask : chk_reg
    task automatic chk_vec(input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED %0t vector exp %h got %h", $time, exp, got);
        end
    endtask : chk_vec
    task automatic give_verdict();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : give_verdict
    // Expected vector by priority rank
    function automatic logic [7:0] exp_vec(input int i);
        return 8'h04 + 8'(4 * i);
    endfunction : exp_vec
    // Watchdog
    initial
    begin
        repeat (5000) @(posedge clk);
        n_errors++;
        give_verdict();
    end
    // Main sequence; stack held full during register tests
    initial
    begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            apb(0, adr[i], 8'h00);
            chk_reg(8'h00, q);
            repeat (3)
            begin
                d = 8'($random(seed));
                apb(1, adr[i], d);
                apb(0, adr[i], 8'h00);
                chk_reg(d & msk[i], q);
            end
            apb(1, adr[i], 8'h00);
        end
        apb(0, 10'h3FC, 8'h00);
        chk_reg(8'h01, {7'h0, e});
        apb(1, adr[3], 8'h10);
        apb(1, adr[1], 8'h07);
        apb(1, adr[0], 8'h0F);
        events <= 6'h3F;
        @(posedge clk);
        events <= 6'h00;
        repeat (4) @(posedge clk);
        chk_reg(8'h00, 8'(vq.size()));
        chk_reg(8'h01, {7'h0, wake});
        apb(0, adr[0], 8'h00);
        chk_reg(8'h7F, q);
        apb(0, adr[1], 8'h00);
        chk_reg(8'h77, q);
        {hold, auto_ret} <= 2'b01;
        for (int k = 0; k < 300 && vq.size() < 6; k++) @(posedge clk);
        repeat (8) @(posedge clk);
        chk_reg(8'h06, 8'(vq.size()));
        foreach (vq[i]) chk_vec(exp_vec(i), vq[i]);
        apb(0, adr[0], 8'h00);
        chk_reg(8'h0F, q);
        apb(0, adr[1], 8'h00);
        chk_reg(8'h07, q);
        chk_reg(8'h00, {7'h0, wake});
        pin <= 1'b1;
        repeat (6) @(posedge clk);
        apb(0, adr[3], 8'h00);
        chk_reg(8'h16, q);
        auto_ret <= 1'b0;
        events <= 6'h30;
        @(posedge clk);
        events <= 6'h00;
        repeat (4) @(posedge clk);
        chk_reg(8'h07, 8'(vq.size()));
        apb(1, adr[0], 8'h2F);
        repeat (4) @(posedge clk);
        chk_vec(8'h04, vq[6]);
        chk_vec(8'h08, vq[7]);
        apb(0, adr[3], 8'h00);
        chk_reg(8'h16, q);
        give_verdict();
    end
endmodule : mcu_interrupt_control_tb
bind mcu_interrupt_control mcu_interrupt_control_monitor mon (.i_clock(i_clock),
    .i_nrst(i_nrst), .i_psel(i_psel), .i_penable(i_penable),
    .i_instr_boundary(i_instr_boundary), .i_stack_full(i_stack_full),
    .i_return_from_interrupt(i_return_from_interrupt), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .o_ack(o_ack), .o_wake(o_wake));
